// *** inc/io_space_pkg.sv ***
// constants, types and helpers for the low i/o register space
package io_space_pkg;

   // ----------------------------------------
   // i/o locations
   // ----------------------------------------
   localparam logic [5:0] IO_PORT_B_OUTPUT_PIN  = 6'h03;
   localparam logic [5:0] IO_PORT_B_OUTPUT_DIR  = 6'h04;
   localparam logic [5:0] IO_PORT_B_OUTPUT_OUT  = 6'h05;
   localparam logic [5:0] IO_PORT_C_OUTPUT_PIN  = 6'h06;
   localparam logic [5:0] IO_PORT_C_OUTPUT_DIR  = 6'h07;
   localparam logic [5:0] IO_PORT_C_OUTPUT_OUT  = 6'h08;
   localparam logic [5:0] IO_PORT_D_OUTPUT_PIN  = 6'h09;
   localparam logic [5:0] IO_PORT_D_OUTPUT_DIR  = 6'h0a;
   localparam logic [5:0] IO_PORT_D_OUTPUT_OUT  = 6'h0b;
   localparam logic [5:0] IO_T0_FLAGS   = 6'h15;
   localparam logic [5:0] IO_T1_FLAGS   = 6'h16;
   localparam logic [5:0] IO_T2_FLAGS   = 6'h17;
   localparam logic [5:0] IO_PC_FLAGS   = 6'h1b;
   localparam logic [5:0] IO_EXT_FLAGS  = 6'h1c;
   localparam logic [5:0] IO_EXT_MASK   = 6'h1d;
   localparam logic [5:0] IO_GP0        = 6'h1e;
   localparam logic [5:0] IO_NVM_CTRL   = 6'h1f;
   localparam logic [5:0] IO_NVM_DATA   = 6'h20;
   localparam logic [5:0] IO_NVM_ADRL   = 6'h21;
   localparam logic [5:0] IO_NVM_ADRH   = 6'h22;
   localparam logic [5:0] IO_PSC_CTRL   = 6'h23;
   localparam logic [5:0] IO_T0_CTRL_A  = 6'h24;
   localparam logic [5:0] IO_T0_CTRL_B  = 6'h25;
   localparam logic [5:0] IO_T0_COUNT   = 6'h26;
   localparam logic [5:0] IO_T0_CMP_A   = 6'h27;
   localparam logic [5:0] IO_T0_CMP_B   = 6'h28;
   localparam logic [5:0] IO_LAST_IMPL  = 6'h28;
   localparam logic [5:0] IO_BIT_LAST   = 6'h1f;

   // ----------------------------------------
   // data space map
   // ----------------------------------------
   localparam logic [7:0] MEM_IO_OFFSET = 8'h20;
   localparam logic [7:0] MEM_IO_LAST   = 8'h5f;
   localparam logic [7:0] MEM_EXT_BASE  = 8'h60;

   // ----------------------------------------
   // field masks and reset value
   // ----------------------------------------
   localparam logic [7:0] RESET_VAL     = 8'h00;
   localparam logic [7:0] FULL_MASK     = 8'hff;
   localparam logic [7:0] PORT_C_OUTPUT_MASK    = 8'h7f;
   localparam logic [7:0] T_FLAG_MASK   = 8'h07;
   localparam logic [7:0] T1_FLAG_MASK  = 8'h27;
   localparam logic [7:0] PC_FLAG_MASK  = 8'h07;
   localparam logic [7:0] EXT_FLAG_MASK = 8'h03;
   localparam logic [7:0] EXT_MASK_BITS = 8'h03;
   localparam logic [7:0] NVM_CTRL_MASK = 8'h3f;
   localparam logic [7:0] PSC_MASK      = 8'h83;
   localparam logic [7:0] T0_A_MASK     = 8'hf3;
   localparam logic [7:0] T0_B_MASK     = 8'hcf;

   typedef enum logic [1:0] {
      SET_IO_BIT_OP        = 2'h0,
      CLEAR_IO_BIT_OP      = 2'h1,
      SKIP_IF_IO_BIT_SET   = 2'h2,
      SKIP_IF_IO_BIT_CLEAR = 2'h3
   } bit_kind_t;

   typedef enum logic [1:0] {
      ST_IDLE     = 2'b01,
      ST_EXT_WAIT = 2'b10
   } seq_state_t;

   // software-writable bits of each location; zero for reserved
   function automatic logic [7:0] rw_mask(input logic [5:0] a);
      unique case (a)
         IO_PORT_B_OUTPUT_DIR, IO_PORT_B_OUTPUT_OUT, IO_PORT_D_OUTPUT_DIR, IO_PORT_D_OUTPUT_OUT: rw_mask = FULL_MASK;
         IO_PORT_C_OUTPUT_DIR, IO_PORT_C_OUTPUT_OUT:                              rw_mask = PORT_C_OUTPUT_MASK;
         IO_EXT_MASK:                                             rw_mask = EXT_MASK_BITS;
         IO_NVM_CTRL:                                             rw_mask = NVM_CTRL_MASK;
         IO_PSC_CTRL:                                             rw_mask = PSC_MASK;
         IO_T0_CTRL_A:                                            rw_mask = T0_A_MASK;
         IO_T0_CTRL_B:                                            rw_mask = T0_B_MASK;
         IO_GP0, IO_NVM_DATA, IO_NVM_ADRL, IO_NVM_ADRH,
         IO_T0_COUNT, IO_T0_CMP_A, IO_T0_CMP_B:                   rw_mask = FULL_MASK;
         default:                                                 rw_mask = RESET_VAL;
      endcase
   endfunction

   // status flags that clear on a written one
   function automatic logic [7:0] w1c_mask(input logic [5:0] a);
      unique case (a)
         IO_T0_FLAGS, IO_T2_FLAGS: w1c_mask = T_FLAG_MASK;
         IO_T1_FLAGS:              w1c_mask = T1_FLAG_MASK;
         IO_PC_FLAGS:              w1c_mask = PC_FLAG_MASK;
         IO_EXT_FLAGS:             w1c_mask = EXT_FLAG_MASK;
         default:                  w1c_mask = RESET_VAL;
      endcase
   endfunction

endpackage

// *** core/pin_sync.sv ***
// two-stage synchroniser for port pin levels
`timescale 1ns/10ps
module pin_sync
   import io_space_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_q;

   // ----------------------------------------
   // two flops, first read only by second
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else if (ce) begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

// *** core/io_addr_map.sv ***
// maps direct i/o and data-space addresses onto i/o locations
`timescale 1ns/10ps
module io_addr_map
   import io_space_pkg::*;
(
   input  wire logic       io_sel,
   input  wire logic [5:0] io_addr,
   input  wire logic       mem_sel,
   input  wire logic [7:0] mem_addr,
   output logic            hit_io,
   output logic [5:0]      idx,
   output logic            bit_ok,
   output logic            hit_ext
);

   logic [7:0] mem_off;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   always_comb begin
      mem_off = mem_addr - MEM_IO_OFFSET;
      hit_io  = 1'b0;
      idx     = 6'h00;
      bit_ok  = 1'b0;
      hit_ext = 1'b0;
      if (io_sel) begin
         // direct transfers carry only the i/o location, never the alias
         hit_io = 1'b1;
         idx    = io_addr;
         bit_ok = (io_addr <= IO_BIT_LAST);
      end else if (mem_sel) begin
         if (mem_addr >= MEM_EXT_BASE) begin
            hit_ext = 1'b1;
         end else if (mem_addr >= MEM_IO_OFFSET) begin
            hit_io = 1'b1;
            idx    = mem_off[5:0];
         end
      end
   end

endmodule

// *** core/io_space_decoder.sv ***
// low i/o register space: direct, bit and data-space access
// ----------------------------------------
// What this block does
// - bit set/clear only on locations 0x00-0x1f
// - bit test and skip in bit range
// - writing one clears status flags
// - bit operations touch only the addressed bit
// - direct transfers use 6-bit locations 0x00-0x3f
// - data-space alias is location plus 0x20
// - extended 0x60-0xff only by load/store
// - direct transfers use i/o locations only
// ----------------------------------------
`timescale 1ns/10ps
module io_space_decoder
   import io_space_pkg::*;
(
   input  wire logic       CLOCK,
   input  wire logic       RST,
   input  wire logic       CE,
   input  wire logic       IO_REQ,
   input  wire logic       IO_WE,
   input  wire logic [5:0] IO_ADDR,
   input  wire logic       BIT_REQ,
   input  wire logic [1:0] BIT_KIND,
   input  wire logic [2:0] BIT_NUM,
   input  wire logic       MEM_REQ,
   input  wire logic       MEM_WE,
   input  wire logic [7:0] MEM_ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic [7:0] EXT_RDATA,
   input  wire logic [7:0] PORT_B_PINS,
   input  wire logic [7:0] PORT_C_PINS,
   input  wire logic [7:0] PORT_D_PINS,
   input  wire logic [7:0] T0_FLAG_SET,
   input  wire logic [7:0] T1_FLAG_SET,
   input  wire logic [7:0] T2_FLAG_SET,
   input  wire logic [7:0] PC_FLAG_SET,
   input  wire logic [7:0] EXT_FLAG_SET,
   output logic      [7:0] RDATA,
   output logic            RVALID,
   output logic            SKIP,
   output logic            EXT_RE,
   output logic            EXT_WE,
   output logic      [7:0] EXT_ADDR,
   output logic      [7:0] EXT_WDATA,
   output logic      [7:0] PORT_B_DIR,
   output logic      [7:0] PORT_B_OUT,
   output logic      [7:0] PORT_C_DIR,
   output logic      [7:0] PORT_C_OUT,
   output logic      [7:0] PORT_D_DIR,
   output logic      [7:0] PORT_D_OUT
);

   logic [7:0]  regs_q [0:IO_LAST_IMPL];
   logic [7:0]  pin_b;
   logic [7:0]  pin_c;
   logic [7:0]  pin_d;
   logic        io_sel;
   logic        mem_sel;
   logic        hit_io;
   logic [5:0]  idx;
   logic        bit_ok;
   logic        hit_ext;
   logic [7:0]  cur;
   logic [7:0]  onehot;
   logic        wr_en;
   logic [7:0]  wr_data;
   logic        rd_en;
   logic        test_en;
   logic        test_hit;
   seq_state_t  state_q;
   seq_state_t  state_d;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   pin_sync #(.W(8)) u_sync_b (
      .clk      (CLOCK),
      .rst      (RST),
      .ce       (CE),
      .async_in (PORT_B_PINS),
      .sync_out (pin_b)
   );

   pin_sync #(.W(8)) u_sync_c (
      .clk      (CLOCK),
      .rst      (RST),
      .ce       (CE),
      .async_in (PORT_C_PINS),
      .sync_out (pin_c)
   );

   pin_sync #(.W(8)) u_sync_d (
      .clk      (CLOCK),
      .rst      (RST),
      .ce       (CE),
      .async_in (PORT_D_PINS),
      .sync_out (pin_d)
   );

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   // i/o side wins when core raises both; requests are refused during ext wait
   assign io_sel  = (IO_REQ | BIT_REQ) && state_q == ST_IDLE;
   assign mem_sel = MEM_REQ && state_q == ST_IDLE;

   io_addr_map u_map (
      .io_sel   (io_sel),
      .io_addr  (IO_ADDR),
      .mem_sel  (mem_sel),
      .mem_addr (MEM_ADDR),
      .hit_io   (hit_io),
      .idx      (idx),
      .bit_ok   (bit_ok),
      .hit_ext  (hit_ext)
   );

   // visible value of a location; reserved bits and locations read zero
   function automatic logic [7:0] read_io(input logic [5:0] a);
      logic [7:0] v;
      v = RESET_VAL;
      unique case (a)
         IO_PORT_B_OUTPUT_PIN: v = pin_b;
         IO_PORT_C_OUTPUT_PIN: v = pin_c & PORT_C_OUTPUT_MASK;
         IO_PORT_D_OUTPUT_PIN: v = pin_d;
         default: begin
            if (a <= IO_LAST_IMPL) begin
               v = regs_q[a] & (rw_mask(a) | w1c_mask(a));
            end
         end
      endcase
      return v;
   endfunction

   // ----------------------------------------
   // access control
   // ----------------------------------------
   always_comb begin
      cur      = read_io(idx);
      onehot   = 8'h01 << BIT_NUM;
      wr_en    = 1'b0;
      wr_data  = RESET_VAL;
      rd_en    = 1'b0;
      test_en  = 1'b0;
      test_hit = 1'b0;
      if (hit_io && BIT_REQ) begin
         if (bit_ok) begin
            unique case (bit_kind_t'(BIT_KIND))
               SET_IO_BIT_OP: begin
                  // flags of the same register see zero except the chosen bit
                  wr_en   = 1'b1;
                  wr_data = (cur & rw_mask(idx)) | onehot;
               end
               CLEAR_IO_BIT_OP: begin
                  wr_en   = 1'b1;
                  wr_data = (cur & rw_mask(idx)) & ~onehot;
               end
               SKIP_IF_IO_BIT_SET: begin
                  test_en  = 1'b1;
                  test_hit = |(cur & onehot);
               end
               SKIP_IF_IO_BIT_CLEAR: begin
                  test_en  = 1'b1;
                  test_hit = ~|(cur & onehot);
               end
            endcase
         end
      end else if (hit_io) begin
         wr_en   = (IO_REQ ? IO_WE : MEM_WE);
         wr_data = WDATA;
         rd_en   = ~wr_en;
      end
   end

   // ----------------------------------------
   // register storage
   // ----------------------------------------
   // masks stop reserved writes, so no location outside the map changes
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         for (int i = 0; i <= int'(IO_LAST_IMPL); i++) begin
            regs_q[i] <= RESET_VAL;
         end
      end else if (CE) begin
         for (int i = 0; i <= int'(IO_LAST_IMPL); i++) begin
            logic [5:0] a;
            logic [7:0] rw;
            logic [7:0] fl;
            logic [7:0] clr;
            logic [7:0] v;
            a   = i[5:0];
            rw  = rw_mask(a);
            fl  = w1c_mask(a);
            clr = RESET_VAL;
            v   = regs_q[i];
            if (wr_en && idx == a) begin
               v   = (v & ~rw) | (wr_data & rw);
               clr = wr_data & fl;
            end
            // a flag event in the clearing cycle is kept
            unique case (a)
               IO_T0_FLAGS:  v = (v & ~clr) | (T0_FLAG_SET & fl);
               IO_T1_FLAGS:  v = (v & ~clr) | (T1_FLAG_SET & fl);
               IO_T2_FLAGS:  v = (v & ~clr) | (T2_FLAG_SET & fl);
               IO_PC_FLAGS:  v = (v & ~clr) | (PC_FLAG_SET & fl);
               IO_EXT_FLAGS: v = (v & ~clr) | (EXT_FLAG_SET & fl);
               default:      v = v;
            endcase
            regs_q[i] <= v;
         end
      end
   end

   // ----------------------------------------
   // extended region sequencing
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (hit_ext && !MEM_WE) begin
               state_d = ST_EXT_WAIT;
            end
         end
         ST_EXT_WAIT: state_d = ST_IDLE;
         default:     state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         state_q <= ST_IDLE;
      end else if (CE) begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         EXT_RE    <= 1'b0;
         EXT_WE    <= 1'b0;
         EXT_ADDR  <= RESET_VAL;
         EXT_WDATA <= RESET_VAL;
      end else if (CE) begin
         EXT_RE <= hit_ext && !MEM_WE;
         EXT_WE <= hit_ext && MEM_WE;
         if (hit_ext) begin
            EXT_ADDR  <= MEM_ADDR;
            EXT_WDATA <= WDATA;
         end
      end
   end

   // ----------------------------------------
   // read answer and skip
   // ----------------------------------------
   // ext reads cost one extra cycle so the answer still comes from a flop
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         RDATA  <= RESET_VAL;
         RVALID <= 1'b0;
      end else if (CE) begin
         RVALID <= 1'b0;
         if (state_q == ST_EXT_WAIT) begin
            RDATA  <= EXT_RDATA;
            RVALID <= 1'b1;
         end else if (rd_en) begin
            RDATA  <= cur;
            RVALID <= 1'b1;
         end else if (mem_sel && !hit_io && !hit_ext && !MEM_WE) begin
            RDATA  <= RESET_VAL;
            RVALID <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         SKIP <= 1'b0;
      end else if (CE) begin
         SKIP <= test_en && test_hit;
      end
   end

   // ----------------------------------------
   // port outputs
   // ----------------------------------------
   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         PORT_B_DIR <= RESET_VAL;
         PORT_B_OUT <= RESET_VAL;
         PORT_C_DIR <= RESET_VAL;
         PORT_C_OUT <= RESET_VAL;
         PORT_D_DIR <= RESET_VAL;
         PORT_D_OUT <= RESET_VAL;
      end else if (CE) begin
         PORT_B_DIR <= regs_q[IO_PORT_B_OUTPUT_DIR];
         PORT_B_OUT <= regs_q[IO_PORT_B_OUTPUT_OUT];
         PORT_C_DIR <= regs_q[IO_PORT_C_OUTPUT_DIR];
         PORT_C_OUT <= regs_q[IO_PORT_C_OUTPUT_OUT];
         PORT_D_DIR <= regs_q[IO_PORT_D_OUTPUT_DIR];
         PORT_D_OUT <= regs_q[IO_PORT_D_OUTPUT_OUT];
      end
   end

endmodule

// *** verif/io_space_decoder_assertions.sv ***
// port checks for the i/o space decoder
`timescale 1ns/10ps
module io_space_assert (
   input wire logic       CLOCK,
   input wire logic       RST,
   input wire logic       CE,
   input wire logic       IO_REQ,
   input wire logic       IO_WE,
   input wire logic [5:0] IO_ADDR,
   input wire logic       BIT_REQ,
   input wire logic [1:0] BIT_KIND,
   input wire logic [2:0] BIT_NUM,
   input wire logic       MEM_REQ,
   input wire logic       MEM_WE,
   input wire logic [7:0] MEM_ADDR,
   input wire logic [7:0] WDATA,
   input wire logic [7:0] EXT_RDATA,
   input wire logic [7:0] RDATA,
   input wire logic       RVALID,
   input wire logic       SKIP,
   input wire logic       EXT_RE,
   input wire logic       EXT_WE,
   input wire logic [7:0] EXT_ADDR,
   input wire logic [7:0] EXT_WDATA,
   input wire logic [7:0] PORT_B_OUT
);
   // ----------
   // helpers
   // ----------
   // nothing is taken in the wait cycle after an ext read
   wire logic tk  = CE && !EXT_RE;
   wire logic mrd = tk && !IO_REQ && !BIT_REQ && MEM_REQ && !MEM_WE;
   wire logic mwr = tk && !IO_REQ && !BIT_REQ && MEM_REQ && MEM_WE;
   wire logic bop = tk && BIT_REQ && IO_ADDR == 6'h05;

   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (RST);

   // ----------
   // checks
   // ----------
   port_b_write_a :
   assert property (((tk && IO_REQ && !BIT_REQ && IO_WE && IO_ADDR == 6'h05) || (mwr && MEM_ADDR == 8'h25))
      ##1 CE |=> PORT_B_OUT == $past(WDATA, 2)) else $error("port b output missed a write");
   reserved_zero_a :
   assert property (tk && IO_REQ && !BIT_REQ && !IO_WE && (IO_ADDR > 6'h28 || IO_ADDR inside {[6'h0c:6'h14]})
      |=> RVALID && RDATA == 8'h00) else $error("reserved read not zero");
   low_data_a :
   assert property (mrd && MEM_ADDR < 8'h20 |=> RVALID && RDATA == 8'h00)
      else $error("low data read not zero");
   bit_range_a :
   assert property (tk && BIT_REQ && IO_ADDR > 6'h1f |=> !SKIP && !RVALID)
      else $error("bit op above range answered");
   bit_set_a :
   assert property (bop && BIT_KIND == 2'h0 ##1 CE
      |=> PORT_B_OUT == ($past(PORT_B_OUT) | 8'h01 << $past(BIT_NUM, 2))) else $error("bit set wrong");
   bit_clear_a :
   assert property (bop && BIT_KIND == 2'h1 ##1 CE
      |=> PORT_B_OUT == ($past(PORT_B_OUT) & ~(8'h01 << $past(BIT_NUM, 2)))) else $error("bit clear wrong");
   skip_test_a :
   assert property (bop && BIT_KIND[1] |=> SKIP == (PORT_B_OUT[$past(BIT_NUM)] ^ $past(BIT_KIND[0])))
      else $error("skip flag wrong");
   ext_read_a :
   assert property (mrd && MEM_ADDR >= 8'h60 |=> EXT_RE && EXT_ADDR == $past(MEM_ADDR)
      ##1 RVALID && RDATA == $past(EXT_RDATA)) else $error("ext read wrong");
   ext_write_a :
   assert property (mwr && MEM_ADDR >= 8'h60 |=> EXT_WE && EXT_WDATA == $past(WDATA))
      else $error("ext write wrong");
   ext_cause_a :
   assert property (EXT_RE || EXT_WE |-> $past(MEM_REQ && !IO_REQ && !BIT_REQ && MEM_ADDR >= 8'h60))
      else $error("ext access without load or store");
endmodule

// *** verif/ext_region_model.sv ***
// extended data region standing behind the decoder
`timescale 1ns/10ps
module ext_region_model (
   input  wire logic       clk,
   input  wire logic       re,
   input  wire logic       we,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata
);
   logic [7:0] mem_q [0:255];
   logic [7:0] last_q = 8'h00;
   always_ff @(posedge clk) begin
      if (we) mem_q[addr] <= wdata;
      if (re) last_q <= mem_q[addr];
   end
   // outside a read the bus shows no stale data
   assign rdata = re ? mem_q[addr] : ~last_q;
endmodule

// *** verif/io_space_decoder_tb.sv ***
// self-checking bench for the i/o space decoder
`timescale 1ns/10ps
module io_space_decoder_tb;
   typedef struct packed {
      logic [1:0] op;
      logic       we;
      logic [1:0] kind;
      logic [2:0] num;
      logic [7:0] addr;
      logic [7:0] wd;
      logic [7:0] ed;
   } row_t;
   logic       CLOCK = 1'b0, RST = 1'b1, CE = 1'b1, IO_REQ = 1'b0, IO_WE = 1'b0;
   logic       BIT_REQ = 1'b0, MEM_REQ = 1'b0, MEM_WE = 1'b0;
   logic [1:0] BIT_KIND = 2'h0;
   logic [2:0] BIT_NUM = 3'h0;
   logic [5:0] IO_ADDR = 6'h00;
   logic [7:0] MEM_ADDR = 8'h00, WDATA = 8'h00, PORT_B_PINS = 8'h5a, PORT_C_PINS = 8'hbc;
   logic [7:0] PORT_D_PINS = 8'hc3, T0_FLAG_SET = 8'h00, T1_FLAG_SET = 8'h00;
   logic [7:0] T2_FLAG_SET = 8'h00, PC_FLAG_SET = 8'h00, EXT_FLAG_SET = 8'h00;
   logic       RVALID, SKIP, EXT_RE, EXT_WE;
   logic [7:0] EXT_RDATA, RDATA, EXT_ADDR, EXT_WDATA, PORT_B_DIR, PORT_B_OUT;
   logic [7:0] PORT_C_DIR, PORT_C_OUT, PORT_D_DIR, PORT_D_OUT;
   int         n_errors = 0;
   int         comparisons = 0;
   // op: 0 direct, 1 bit op, 2 load/store; ed is read data or skip in bit 0
   localparam row_t ROWS [29] = '{
      '{0,1,0,0,8'h05,8'ha5,0}, '{0,0,0,0,8'h05,0,8'ha5}, '{2,0,0,0,8'h25,0,8'ha5},
      '{2,1,0,0,8'h28,8'h7f,0}, '{0,0,0,0,8'h08,0,8'h7f}, '{0,1,0,0,8'h03,8'hff,0},
      '{0,0,0,0,8'h03,0,8'h5a}, '{0,0,0,0,8'h06,0,8'h3c}, '{2,0,0,0,8'h29,0,8'hc3},
      '{0,1,0,0,8'h0c,8'h77,0}, '{0,0,0,0,8'h0c,0,0}, '{0,0,0,0,8'h3f,0,0},
      '{2,0,0,0,8'h10,0,0}, '{2,0,0,0,8'h5f,0,0},
      '{1,0,1,0,8'h05,0,0}, '{1,0,0,1,8'h05,0,0}, '{0,0,0,0,8'h05,0,8'ha6},
      '{1,0,2,1,8'h05,0,1}, '{1,0,3,1,8'h05,0,0}, '{1,0,3,0,8'h05,0,1}, '{1,0,2,0,8'h05,0,0},
      '{0,1,0,0,8'h20,8'h00,0}, '{1,0,0,3,8'h20,0,0}, '{0,0,0,0,8'h20,0,0}, '{1,0,3,3,8'h20,0,0},
      '{2,1,0,0,8'h60,8'h3c,0}, '{2,0,0,0,8'h60,0,8'h3c}, '{2,1,0,0,8'hff,8'hc5,0}, '{2,0,0,0,8'hff,0,8'hc5}
   };
   localparam logic [7:0] FA [5] = '{8'h15, 8'h16, 8'h17, 8'h1b, 8'h1c};
   localparam logic [7:0] FM [5] = '{8'h07, 8'h27, 8'h07, 8'h07, 8'h03};

   io_space_decoder io_space_decoder_inst (.*);
   ext_region_model ext_region_model_inst (.clk(CLOCK), .re(EXT_RE), .we(EXT_WE), .addr(EXT_ADDR),
      .wdata(EXT_WDATA), .rdata(EXT_RDATA));

   always #10 CLOCK = ~CLOCK;

   // ----------
   // tasks
   // ----------
   task automatic do_op(input row_t r);
      @(posedge CLOCK);
      IO_REQ   <= r.op == 2'h0;
      BIT_REQ  <= r.op == 2'h1;
      MEM_REQ  <= r.op == 2'h2;
      IO_WE    <= r.we;
      MEM_WE   <= r.we;
      BIT_KIND <= r.kind;
      BIT_NUM  <= r.num;
      IO_ADDR  <= r.addr[5:0];
      MEM_ADDR <= r.addr;
      WDATA    <= r.wd;
      @(posedge CLOCK);
      IO_REQ  <= 1'b0;
      BIT_REQ <= 1'b0;
      MEM_REQ <= 1'b0;
      #1;
      // ext reads answer one cycle later
      if (r.op == 2'h2 && !r.we && r.addr >= 8'h60) begin
         @(posedge CLOCK);
         #1;
      end
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run;
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (2000) @(posedge CLOCK);
      n_errors++;
      complete_run();
   end

   // ----------
   // scenarios
   // ----------
   initial begin
      repeat (3) @(posedge CLOCK);
      RST <= 1'b0;
      foreach (ROWS[i]) begin
         do_op(ROWS[i]);
         if (ROWS[i].op == 2'h1 && ROWS[i].kind[1])
            chk("skip", {7'h0, ROWS[i].ed[0]}, {7'h0, SKIP});
         else if (!ROWS[i].we && ROWS[i].op != 2'h1) begin
            chk("answer", 8'h01, {7'h0, RVALID});
            chk("read data", ROWS[i].ed, RDATA);
         end
      end
      chk("port c out", 8'h7f, PORT_C_OUT);
      do_op('{0,1,0,0,8'h04,8'h11,0});
      do_op('{0,1,0,0,8'h07,8'h22,0});
      do_op('{2,1,0,0,8'h2a,8'h33,0});
      do_op('{2,1,0,0,8'h2b,8'h44,0});
      @(posedge CLOCK);
      #1;
      chk("port b dir", 8'h11, PORT_B_DIR);
      chk("port c dir", 8'h22, PORT_C_DIR);
      chk("port d dir", 8'h33, PORT_D_DIR);
      chk("port d out", 8'h44, PORT_D_OUT);
      @(posedge CLOCK);
      {T0_FLAG_SET, T1_FLAG_SET, T2_FLAG_SET, PC_FLAG_SET, EXT_FLAG_SET} <= {5{8'hff}};
      @(posedge CLOCK);
      {T0_FLAG_SET, T1_FLAG_SET, T2_FLAG_SET, PC_FLAG_SET, EXT_FLAG_SET} <= {5{8'h00}};
      for (int i = 0; i < 5; i++) begin
         do_op('{0,0,0,0,FA[i],0,0});
         chk("flags set", FM[i], RDATA);
         do_op('{0,1,0,0,FA[i],8'h01,0});
         do_op('{0,0,0,0,FA[i],0,0});
         chk("flags after one written", FM[i] & 8'hfe, RDATA);
         do_op('{1,0,1,1,FA[i],0,0});
         do_op('{0,0,0,0,FA[i],0,0});
         chk("flags after bit clear", FM[i] & 8'hfe, RDATA);
         do_op('{1,0,0,1,FA[i],0,0});
         do_op('{0,0,0,0,FA[i],0,0});
         chk("flags after bit ops", FM[i] & 8'hfc, RDATA);
      end
      // a flag event in the clearing cycle must survive
      @(posedge CLOCK);
      T0_FLAG_SET <= 8'h01;
      do_op('{0,1,0,0,8'h15,8'h01,0});
      T0_FLAG_SET <= 8'h00;
      do_op('{0,0,0,0,8'h15,0,0});
      chk("flag set beats clear", 8'h05, RDATA);
      // frozen clock enable must drop the write
      @(posedge CLOCK);
      CE <= 1'b0;
      do_op('{0,1,0,0,8'h05,8'h00,0});
      @(posedge CLOCK);
      CE <= 1'b1;
      do_op('{0,0,0,0,8'h05,0,0});
      chk("frozen write", 8'ha6, RDATA);
      @(posedge CLOCK);
      RST <= 1'b1;
      @(posedge CLOCK);
      #1;
      chk("port b out in reset", 8'h00, PORT_B_OUT);
      @(posedge CLOCK);
      RST <= 1'b0;
      do_op('{0,0,0,0,8'h05,0,0});
      chk("read after reset", 8'h00, RDATA);
      complete_run();
   end
endmodule

bind io_space_decoder io_space_assert io_space_assert_inst (.*);
